//--- hw/chunk_pkg.sv
// package: register map, chunk kinds and layout constants for the appender
package chunk_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_SELECT   = 8'h04;
	localparam logic [7:0] ADDR_KIND_ON  = 8'h08;
	localparam logic [7:0] ADDR_SEQ_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_SNAPSHOT = 8'h14;
	localparam logic [7:0] ADDR_CRC      = 8'h18;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          MODE_BIT       = 0;
	localparam int          SEQ_EN_BIT     = 0;
	localparam int          SEQ_IDX_LSB    = 8;
	localparam int          SEQ_IDX_W      = 8;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_KIND_LSB  = 4;
	localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;

	// ----------------------------------------------------------------
	// chunk kinds, one enable bit each
	// ----------------------------------------------------------------
	localparam int          NUM_KINDS      = 3;
	localparam logic [1:0]  KIND_LINES     = 2'h0;
	localparam logic [1:0]  KIND_SEQ_INDEX = 2'h1;
	localparam logic [1:0]  KIND_CHECKSUM  = 2'h2;

	// ----------------------------------------------------------------
	// snapshot bit assignment: 1 marks a bit that carries a line
	// ----------------------------------------------------------------
	localparam logic [31:0] LINE_BIT_MAP   = 32'h0000_00FF;

	// ----------------------------------------------------------------
	// stream and crc
	// ----------------------------------------------------------------
	localparam int          DATA_W         = 32;
	localparam int          FIFO_DEPTH     = 4;
	localparam logic [15:0] CRC_POLY       = 16'h1021;
	localparam logic [15:0] CRC_INIT       = 16'h0000;

	// ----------------------------------------------------------------
	// axi responses
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_IMAGE = 3'b001,
		ST_LINES = 3'b011,
		ST_SEQ   = 3'b010,
		ST_CRC   = 3'b110
	} frame_state_t;

endpackage

//--- hw/stream_fifo.sv
// module: small valid/ready fifo with parameterised width and depth
`timescale 1ns/10ps
module stream_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_reg];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- hw/crc_xmodem.sv
// module: x-modem crc-16 accumulator over 32-bit words, msb byte first
`timescale 1ns/10ps
module crc_xmodem
	import chunk_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic        word_en,
	input  wire logic [31:0] word,
	output logic      [15:0] crc
);
	logic [15:0] crc_reg;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
	                                         input logic [7:0]  b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [15:0] crc_word(input logic [15:0] c,
	                                         input logic [31:0] w);
		logic [15:0] r;
		r = c;
		for (int i = 3; i >= 0; i--) begin
			r = crc_byte(r, w[i*8 +: 8]);
		end
		return r;
	endfunction

	assign crc = crc_reg;

	always_ff @(posedge core_clk) begin
		if (rst || clear) begin
			crc_reg <= CRC_INIT;
		end else if (word_en) begin
			crc_reg <= crc_word(crc_reg, word);
		end
	end
endmodule

//--- hw/image_chunk_appender.sv
// module: appends line-level, sequence-index and checksum chunks to images
// Operation
// - trigger captures all line levels per image
// - snapshot is one 32-bit word
// - bit reads 0 low, 1 high
// - kinds enable only with global switch on
// - select kind, set on, append every image
// - checksum chunk carries x-modem crc
// - crc covers payload and chunks, not itself
// - checksum chunk always placed last
// - sequence chunk carries applied set index
// - sequence chunk needs sequencer enabled
`timescale 1ns/10ps
module image_chunk_appender
	import chunk_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	// axi4-lite slave
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// acquisition and lines
	input  wire logic              acq_trigger,
	input  wire logic [31:0]       line_levels,
	input  wire logic [SEQ_IDX_W-1:0] seq_set_index,
	// image payload in
	input  wire logic [DATA_W-1:0] img_data,
	input  wire logic              img_valid,
	input  wire logic              img_last,
	output logic                   img_ready,
	// framed stream out
	output logic [DATA_W-1:0]      out_data,
	output logic                   out_valid,
	output logic                   out_last,
	input  wire logic              out_ready
);
	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic                 mode_reg;
	logic [1:0]           select_reg;
	logic [NUM_KINDS-1:0] kind_on_reg;
	logic                 seq_en_reg;
	logic [31:0]          snapshot_reg;
	logic [SEQ_IDX_W-1:0] seq_idx_reg;
	logic [NUM_KINDS-1:0] frame_kinds_reg;
	logic [15:0]          last_crc_reg;
	frame_state_t         state_reg;
	frame_state_t         state_next;

	// ----------------------------------------------------------------
	// axi write channel
	// ----------------------------------------------------------------
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_do;
	logic        wr_hit;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_do         = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= RESET_ZERO;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		if (aw_addr_reg == ADDR_MODE) begin
			wr_hit = 1'b1;
		end else if (aw_addr_reg == ADDR_SELECT) begin
			wr_hit = 1'b1;
		end else if (aw_addr_reg == ADDR_KIND_ON) begin
			wr_hit = 1'b1;
		end else if (aw_addr_reg == ADDR_SEQ_CTRL) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	logic wr_b0;

	assign wr_b0 = wr_do && w_strb_reg[0];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_reg   <= 1'b0;
			select_reg <= KIND_LINES;
			seq_en_reg <= 1'b0;
		end else if (wr_b0) begin
			if (aw_addr_reg == ADDR_MODE) begin
				mode_reg <= w_data_reg[MODE_BIT];
			end else if (aw_addr_reg == ADDR_SELECT) begin
				select_reg <= w_data_reg[1:0];
			end else if (aw_addr_reg == ADDR_SEQ_CTRL) begin
				seq_en_reg <= w_data_reg[SEQ_EN_BIT];
			end
		end
	end

	// per-kind enable through the selector
	always_ff @(posedge core_clk) begin
		if (rst) begin
			kind_on_reg <= '0;
		end else if (!mode_reg) begin
			kind_on_reg <= '0;
		end else begin
			if (wr_b0 && aw_addr_reg == ADDR_KIND_ON
			    && select_reg < 2'(NUM_KINDS)) begin
				if (w_data_reg[0] && select_reg == KIND_SEQ_INDEX
				    && !seq_en_reg) begin
					kind_on_reg[KIND_SEQ_INDEX] <= 1'b0;
				end else begin
					kind_on_reg[select_reg] <= w_data_reg[0];
				end
			end
			if (!seq_en_reg) begin
				kind_on_reg[KIND_SEQ_INDEX] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic        rd_hit;

	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_hit  = 1'b1;
		if (s_axi_araddr == ADDR_MODE) begin
			rd_word = {31'h0, mode_reg};
		end else if (s_axi_araddr == ADDR_SELECT) begin
			rd_word = {30'h0, select_reg};
		end else if (s_axi_araddr == ADDR_KIND_ON) begin
			rd_word = {31'h0, (select_reg < 2'(NUM_KINDS))
			           && kind_on_reg[select_reg]};
		end else if (s_axi_araddr == ADDR_SEQ_CTRL) begin
			rd_word = {16'h0, seq_idx_reg, 7'h0, seq_en_reg};
		end else if (s_axi_araddr == ADDR_STATUS) begin
			rd_word = {25'h0, frame_kinds_reg, 3'h0,
			           state_reg != ST_IDLE};
		end else if (s_axi_araddr == ADDR_SNAPSHOT) begin
			rd_word = snapshot_reg;
		end else if (s_axi_araddr == ADDR_CRC) begin
			rd_word = {16'h0, last_crc_reg};
		end else begin
			rd_word = RESET_ZERO;
			rd_hit  = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= RESET_ZERO;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// trigger capture
	// ----------------------------------------------------------------
	logic trig_take;

	assign trig_take = acq_trigger && state_reg == ST_IDLE;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			snapshot_reg    <= RESET_ZERO;
			seq_idx_reg     <= '0;
			frame_kinds_reg <= '0;
		end else if (trig_take) begin
			snapshot_reg    <= line_levels & LINE_BIT_MAP;
			seq_idx_reg     <= seq_set_index;
			frame_kinds_reg <= kind_on_reg;
		end
	end

	// ----------------------------------------------------------------
	// framing state machine
	// ----------------------------------------------------------------
	logic              fifo_in_ready;
	logic              fifo_in_valid;
	logic [DATA_W-1:0] fifo_word;
	logic              fifo_last;
	logic              word_go;
	logic [15:0]       crc_now;
	logic              any_tail;

	assign any_tail = |frame_kinds_reg;
	assign img_ready = state_reg == ST_IMAGE && fifo_in_ready;
	assign word_go  = fifo_in_valid && fifo_in_ready;

	always_comb begin
		state_next    = state_reg;
		fifo_in_valid = 1'b0;
		fifo_word     = img_data;
		fifo_last     = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (trig_take) begin
					state_next = ST_IMAGE;
				end
			end
			ST_IMAGE: begin
				fifo_in_valid = img_valid;
				fifo_last     = img_last && !any_tail;
				if (img_valid && fifo_in_ready && img_last) begin
					if (frame_kinds_reg[KIND_LINES]) begin
						state_next = ST_LINES;
					end else if (frame_kinds_reg[KIND_SEQ_INDEX]) begin
						state_next = ST_SEQ;
					end else if (frame_kinds_reg[KIND_CHECKSUM]) begin
						state_next = ST_CRC;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_LINES: begin
				fifo_in_valid = 1'b1;
				fifo_word     = snapshot_reg;
				fifo_last     = !frame_kinds_reg[KIND_SEQ_INDEX]
				                && !frame_kinds_reg[KIND_CHECKSUM];
				if (fifo_in_ready) begin
					if (frame_kinds_reg[KIND_SEQ_INDEX]) begin
						state_next = ST_SEQ;
					end else if (frame_kinds_reg[KIND_CHECKSUM]) begin
						state_next = ST_CRC;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_SEQ: begin
				fifo_in_valid = 1'b1;
				fifo_word     = {24'h0, seq_idx_reg};
				fifo_last     = !frame_kinds_reg[KIND_CHECKSUM];
				if (fifo_in_ready) begin
					state_next = frame_kinds_reg[KIND_CHECKSUM]
					             ? ST_CRC : ST_IDLE;
				end
			end
			ST_CRC: begin
				fifo_in_valid = 1'b1;
				fifo_word     = {16'h0, crc_now};
				fifo_last     = 1'b1;
				if (fifo_in_ready) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			last_crc_reg <= 16'h0000;
		end else if (state_reg == ST_CRC && fifo_in_ready) begin
			last_crc_reg <= crc_now;
		end
	end

	// ----------------------------------------------------------------
	// checksum and output buffering
	// ----------------------------------------------------------------
	crc_xmodem u_crc (
		.core_clk (core_clk),
		.rst      (rst),
		.clear    (trig_take),
		.word_en  (word_go && state_reg != ST_CRC),
		.word     (fifo_word),
		.crc      (crc_now)
	);

	stream_fifo #(
		.WIDTH (DATA_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_data   ({fifo_last, fifo_word}),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  ({out_last, out_data}),
		.out_valid (out_valid),
		.out_ready (out_ready)
	);
endmodule

//--- bench/appender_properties.sv
// checker: port-level properties of the chunk appender
`timescale 1ns/10ps
module appender_checker
	import chunk_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        acq_trigger,
	input wire logic [31:0] line_levels,
	input wire logic        img_ready,
	input wire logic [31:0] out_data,
	input wire logic        out_valid,
	input wire logic        out_last,
	input wire logic        out_ready
);
	// ----------------------------------------------------------------
	// helper: frame in flight and expected snapshot
	// ----------------------------------------------------------------
	logic        busy_h;
	logic [31:0] snap_h;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	always_ff @(posedge core_clk) begin
		if (rst)
			busy_h <= 1'h0;
		else if (acq_trigger && !busy_h)
			busy_h <= 1'h1;
		else if (out_valid && out_ready && out_last)
			busy_h <= 1'h0;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			snap_h <= RESET_ZERO;
		else if (acq_trigger && !busy_h)
			snap_h <= line_levels & LINE_BIT_MAP;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	chk_bvalid_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	chk_out_holds: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data)
		&& $stable(out_last)) else $error("output word changed while stalled");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	chk_addr_blocked: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken during response");
	chk_snap_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_SNAPSHOT
		|=> s_axi_rdata == snap_h) else $error("snapshot value wrong");
	chk_unmapped_rd: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_CRC
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == RESET_ZERO)
		else $error("unmapped read not refused");
	chk_ready_frame: assert property (
		img_ready |-> busy_h) else $error("image taken without trigger");
endmodule

bind image_chunk_appender appender_checker chk_u (
	.core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.acq_trigger(acq_trigger), .line_levels(line_levels),
	.img_ready(img_ready), .out_data(out_data), .out_valid(out_valid),
	.out_last(out_last), .out_ready(out_ready));

//--- bench/host_sink.sv
// partner: host side that takes framed images and checks their crc
`timescale 1ns/10ps
module host_sink
	import chunk_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [31:0] out_data,
	input  wire logic        out_valid,
	input  wire logic        out_last,
	output logic             out_ready,
	input  wire logic        stall,
	input  wire logic        crc_on,
	output logic             frame_done,
	output logic             frame_good
);
	logic [15:0] acc;

	// x-modem step over one word, msb first
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [31:0] w);
		logic fb;
		for (int i = 31; i >= 0; i--) begin
			fb = c[15] ^ w[i];
			c = {c[14:0], 1'h0};
			if (fb)
				c = c ^ CRC_POLY;
		end
		return c;
	endfunction

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_ready  <= 1'h0;
			acc        <= CRC_INIT;
			frame_done <= 1'h0;
			frame_good <= 1'h0;
		end else begin
			out_ready  <= !stall && ($urandom % 4 != 0);
			frame_done <= 1'h0;
			if (out_valid && out_ready) begin
				if (out_last) begin
					acc        <= CRC_INIT;
					frame_done <= crc_on;
					frame_good <= acc == out_data[15:0];
				end else
					acc <= crc_step(acc, out_data);
			end
		end
	end
endmodule

//--- bench/test_image_chunk_appender.sv
// testbench: registers, triggers and images through the appender
`timescale 1ns/10ps
module test_image_chunk_appender
	import chunk_pkg::*;
;
	logic                 core_clk, rst, acq_trigger, img_valid, img_last;
	logic [7:0]           s_axi_awaddr, s_axi_araddr;
	logic [31:0]          s_axi_wdata, s_axi_rdata, line_levels, img_data;
	logic [31:0]          out_data;
	logic [3:0]           s_axi_wstrb;
	logic [1:0]           s_axi_bresp, s_axi_rresp;
	logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic                 s_axi_rready, img_ready, out_valid, out_last;
	logic                 out_ready, stall, crc_on, frame_done, frame_good;
	logic [SEQ_IDX_W-1:0] seq_set_index;
	logic [2:0]           en;
	logic [33:0]          exp_q[$], rd_q[$];
	logic [1:0]           resp_q[$];
	int                   mismatches, n_tests;

	image_chunk_appender dut_u (.*);
	host_sink host_u (.core_clk(core_clk), .rst(rst), .out_data(out_data),
		.out_valid(out_valid), .out_last(out_last), .out_ready(out_ready),
		.stall(stall), .crc_on(crc_on), .frame_done(frame_done),
		.frame_good(frame_good));

	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// compare and bus tasks
	// ----------------------------------------------------------------
	task cmp_word(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ah, wh, bh;
		resp_q.push_back(r);
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do begin
			@(negedge core_clk);
			ah = s_axi_awready;
			wh = s_axi_wready;
			bh = s_axi_bvalid;
			@(posedge core_clk);
			if (ah)
				s_axi_awvalid <= 1'h0;
			if (wh)
				s_axi_wvalid <= 1'h0;
		end while (bh !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask

	task axi_rd(input logic [7:0] a, input logic [33:0] e);
		logic ah, rh;
		rd_q.push_back(e);
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do begin
			@(negedge core_clk);
			ah = s_axi_arready;
			rh = s_axi_rvalid;
			@(posedge core_clk);
			if (ah)
				s_axi_arvalid <= 1'h0;
		end while (rh !== 1'h1);
		s_axi_rready <= 1'h0;
	endtask

	task set_kind(input logic [1:0] k, input logic on, input logic e);
		axi_wr(ADDR_SELECT, {30'h0, k}, RESP_OKAY);
		axi_wr(ADDR_KIND_ON, {31'h0, on}, RESP_OKAY);
		axi_rd(ADDR_KIND_ON, {RESP_OKAY, 31'h0, e});
		en[k] = e;
	endtask

	task frame(input int n);
		logic [31:0] snap, w;
		logic [7:0]  sidx;
		logic [15:0] c;
		logic        h;
		c = CRC_INIT;
		@(posedge core_clk);
		line_levels   <= $urandom;
		seq_set_index <= SEQ_IDX_W'($urandom);
		acq_trigger   <= 1'h1;
		crc_on        <= en[2];
		@(posedge core_clk);
		snap = line_levels & LINE_BIT_MAP;
		sidx = seq_set_index;
		acq_trigger <= 1'h0;
		line_levels <= $urandom;
		for (int i = 0; i < n; i++) begin
			w = $urandom;
			img_data  <= w;
			img_valid <= 1'h1;
			img_last  <= i == n - 1;
			do begin
				@(negedge core_clk);
				h = img_ready;
				@(posedge core_clk);
			end while (h !== 1'h1);
			exp_q.push_back({1'h0, (i == n - 1) && (en == 3'h0), w});
			c = host_u.crc_step(c, w);
		end
		img_valid <= 1'h0;
		img_last  <= 1'h0;
		if (en[0]) begin
			exp_q.push_back({1'h0, en[2:1] == 2'h0, snap});
			c = host_u.crc_step(c, snap);
		end
		if (en[1]) begin
			exp_q.push_back({1'h0, !en[2], 24'h0, sidx});
			c = host_u.crc_step(c, {24'h0, sidx});
		end
		if (en[2])
			exp_q.push_back({2'h1, 16'h0, c});
		while (exp_q.size() != 0)
			@(posedge core_clk);
		if (en[2])
			axi_rd(ADDR_CRC, {RESP_OKAY, 16'h0, c});
		axi_rd(ADDR_SNAPSHOT, {RESP_OKAY, snap});
	endtask

	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// monitor: oldest note against each result seen
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp("bresp", resp_q.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready)
			cmp_word("rdata", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (out_valid && out_ready)
			cmp_word("out", exp_q.pop_front(), {1'h0, out_last, out_data});
		if (frame_done)
			cmp_word("crc_good", 34'h1, {33'h0, frame_good});
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(63));
		{rst, stall, crc_on, en} = 6'h20;
		{acq_trigger, img_valid, img_last, img_data} = 35'h0;
		{line_levels, seq_set_index} = 40'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge core_clk);
		rst <= 1'h0;
		axi_rd(ADDR_MODE, {RESP_OKAY, RESET_ZERO});
		axi_rd(ADDR_STATUS, {RESP_OKAY, RESET_ZERO});
		axi_rd(8'h1C, {RESP_SLVERR, RESET_ZERO});
		axi_wr(8'h1C, 32'h1, RESP_SLVERR);
		for (int k = 0; k < NUM_KINDS; k++)
			set_kind(2'(k), 1'h1, 1'h0);
		axi_wr(ADDR_MODE, 32'h1, RESP_OKAY);
		set_kind(KIND_SEQ_INDEX, 1'h1, 1'h0);
		axi_wr(ADDR_SEQ_CTRL, 32'h1, RESP_OKAY);
		for (int k = 0; k < NUM_KINDS; k++)
			set_kind(2'(k), 1'h1, 1'h1);
		stall <= 1'h1;
		fork
			frame(6);
			begin
				repeat (20) @(posedge core_clk);
				axi_rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0071});
				repeat (17) @(posedge core_clk);
				stall <= 1'h0;
			end
		join
		frame(1);
		set_kind(KIND_LINES, 1'h0, 1'h0);
		frame(3);
		axi_wr(ADDR_SEQ_CTRL, 32'h0, RESP_OKAY);
		axi_wr(ADDR_SELECT, {30'h0, KIND_SEQ_INDEX}, RESP_OKAY);
		axi_rd(ADDR_KIND_ON, {RESP_OKAY, RESET_ZERO});
		en[1] = 1'h0;
		frame(2);
		axi_wr(ADDR_MODE, 32'h0, RESP_OKAY);
		axi_wr(ADDR_SELECT, {30'h0, KIND_CHECKSUM}, RESP_OKAY);
		axi_rd(ADDR_KIND_ON, {RESP_OKAY, RESET_ZERO});
		en = 3'h0;
		frame(2);
		wrap_up;
	end
endmodule
